// File: design/dcr_core.sv
`timescale 1ns/1ps
module dcr_core #(
   parameter int RECAL_CYC = dcr_pkg::RECAL_CYCLES
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic sclk_in,
   input wire logic sync_n_in,
   input wire logic sdi_in,
   input wire logic clear_input_pin_n_in,
   output logic sdo_out,
   output logic sdo_en_out,
   output logic alarm_n_out,
   output logic [19:0] dac_code_out,
   output logic [7:0] cal_coef_out
);
   dcr_pkg::dcr_frame_s frame;
   logic frame_tgl;
   logic bit32_tgl;
   logic [23:0] rd_data_q;
   logic sdo_raw;
   logic [2:0] ftg_q;
   logic [2:0] b32_q;
   logic [2:0] sync_q;
   logic [2:0] clr_q;
   logic frame_ev;
   logic bit32_ev;
   logic sync_rise;
   logic [7:0] clear_code_q;
   logic sdo_en_q;
   logic alarm_en_q;
   logic recal_done_flag_q;
   logic alarm_q;
   logic recal_busy_q;
   logic [15:0] recal_cnt_q;
   logic soft_clear_trigger_pend_q;
   logic [7:0] coef_q;
   logic [19:0] dac_q;
   logic wr;
   logic rd;
   logic soft_reset_trigger;
   default clocking dcr_cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);

   dcr_link u_link (
      .sclk_in(sclk_in),
      .rst_in(rst_in),
      .sync_n_in(sync_n_in),
      .sdi_in(sdi_in),
      .rd_data_in(rd_data_q),
      .sdo_out(sdo_raw),
      .frame_out(frame),
      .frame_tgl_out(frame_tgl),
      .bit32_tgl_out(bit32_tgl)
   );

   // Toggles and pins pass three flops; the third stage is compared with the second, and sync_q[2] also gates sdo_en_out.
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         ftg_q <= 3'h0;
         b32_q <= 3'h0;
         sync_q <= 3'h7;
         clr_q <= 3'h7;
      end
      else
      begin
         ftg_q <= {ftg_q[1:0], frame_tgl};
         b32_q <= {b32_q[1:0], bit32_tgl};
         sync_q <= {sync_q[1:0], sync_n_in};
         clr_q <= {clr_q[1:0], clear_input_pin_n_in};
      end
   end

   assign frame_ev = ftg_q[1] ^ ftg_q[2];
   assign bit32_ev = b32_q[1] ^ b32_q[2];
   assign sync_rise = sync_q[1] & ~sync_q[2];
   // The frame word is stable for a full frame after its toggle.
   assign wr = frame_ev && !frame.rd;
   assign rd = frame_ev && frame.rd;
   assign soft_reset_trigger = wr && frame.addr == dcr_pkg::ADDR_TRIGGER
                 && frame.data[dcr_pkg::TRIG_SOFT_RESET_TRIGGER_BIT];

   // Register file; soft reset restores all defaults.
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         clear_code_q <= dcr_pkg::CLEAR_CODE_RST;
         sdo_en_q <= dcr_pkg::CFG_SDO_EN_RST;
         alarm_en_q <= dcr_pkg::CFG_ALARM_EN_RST;
      end
      else if (soft_reset_trigger)
      begin
         clear_code_q <= dcr_pkg::CLEAR_CODE_RST;
         sdo_en_q <= dcr_pkg::CFG_SDO_EN_RST;
         alarm_en_q <= dcr_pkg::CFG_ALARM_EN_RST;
      end
      else if (wr)
      begin
         // Reserved bits are ignored, so host junk there does no harm.
         if (frame.addr == dcr_pkg::ADDR_CLEAR_CODE)
            clear_code_q <= frame.data[dcr_pkg::CLEAR_CODE_HI:
                                       dcr_pkg::CLEAR_CODE_LO];
         if (frame.addr == dcr_pkg::ADDR_CONFIG)
         begin
            sdo_en_q <= frame.data[dcr_pkg::CFG_SDO_EN_BIT];
            alarm_en_q <= frame.data[dcr_pkg::CFG_ALARM_EN_BIT];
         end
      end
   end

   // Readback word, zero for reserved bits and trigger bits (one-shot).
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
         rd_data_q <= 24'h0;
      else
      begin
         rd_data_q <= 24'h0;
         unique case (frame.addr)
            dcr_pkg::ADDR_CLEAR_CODE:
               rd_data_q[dcr_pkg::CLEAR_CODE_HI:dcr_pkg::CLEAR_CODE_LO]
                  <= clear_code_q;
            dcr_pkg::ADDR_CONFIG:
            begin
               rd_data_q[dcr_pkg::CFG_SDO_EN_BIT] <= sdo_en_q;
               rd_data_q[dcr_pkg::CFG_ALARM_EN_BIT] <= alarm_en_q;
            end
            dcr_pkg::ADDR_STATUS:
               rd_data_q[dcr_pkg::STAT_RECAL_DONE_BIT] <= recal_done_flag_q;
            default: rd_data_q <= 24'h0;
         endcase
      end
   end

   // Recalibration sequencer; the flag and alarm are set when it ends.
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         recal_busy_q <= 1'b0;
         recal_cnt_q <= 16'h0;
         recal_done_flag_q <= 1'b0;
         alarm_q <= 1'b0;
         coef_q <= 8'h00;
      end
      else if (soft_reset_trigger)
      begin
         recal_busy_q <= 1'b0;
         recal_cnt_q <= 16'h0;
         recal_done_flag_q <= 1'b0;
         alarm_q <= 1'b0;
      end
      else if (recal_busy_q && recal_cnt_q == 16'(RECAL_CYC - 1))
      begin
         // Completion wins over a status read in the same cycle.
         recal_busy_q <= 1'b0;
         recal_done_flag_q <= 1'b1;
         alarm_q <= 1'b1;
         coef_q <= coef_q + 8'h01;
      end
      else
      begin
         if (recal_busy_q)
            recal_cnt_q <= recal_cnt_q + 16'h1;
         if (wr && frame.addr == dcr_pkg::ADDR_TRIGGER
             && frame.data[dcr_pkg::TRIG_RECAL_BIT])
         begin
            recal_busy_q <= 1'b1;
            recal_cnt_q <= 16'h0;
            recal_done_flag_q <= 1'b0;
         end
         if (rd && frame.addr == dcr_pkg::ADDR_STATUS)
            alarm_q <= 1'b0;
      end
   end

   // Clear path: pin clear at once, soft clear waits for its update point.
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         soft_clear_trigger_pend_q <= 1'b0;
         dac_q <= 20'h0;
      end
      else if (soft_reset_trigger)
      begin
         soft_clear_trigger_pend_q <= 1'b0;
         dac_q <= 20'h0;
      end
      else
      begin
         if (!clr_q[2] && !clr_q[1])
            dac_q <= {clear_code_q, 12'h000};
         if (frame_ev && !frame.rd && frame.addr == dcr_pkg::ADDR_TRIGGER
             && frame.data[dcr_pkg::TRIG_SOFT_CLEAR_TRIGGER_BIT])
            soft_clear_trigger_pend_q <= 1'b1;
         else if (soft_clear_trigger_pend_q && (sdo_en_q ? bit32_ev : sync_rise))
         begin
            soft_clear_trigger_pend_q <= 1'b0;
            dac_q <= {clear_code_q, 12'h000};
         end
      end
   end

   // Registered outputs.
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         alarm_n_out <= 1'b1;
         sdo_en_out <= 1'b0;
         dac_code_out <= 20'h0;
         cal_coef_out <= 8'h00;
      end
      else
      begin
         alarm_n_out <= ~(alarm_q && alarm_en_q);
         sdo_en_out <= sdo_en_q && !sync_q[2];
         dac_code_out <= dac_q;
         cal_coef_out <= coef_q;
      end
   end

   // Serial data comes straight from the link's falling-edge flop.
   assign sdo_out = sdo_raw;

   property p_alarm_gated;
      !alarm_en_q |=> alarm_n_out;
   endproperty
   a_alarm_gated: assert property (p_alarm_gated)
      else $error("alarm pin low while alarm disabled");
   property p_recal_sets;
      recal_busy_q && recal_cnt_q == 16'(RECAL_CYC - 1) && !soft_reset_trigger
      |=> recal_done_flag_q && !recal_busy_q;
   endproperty
   a_recal_sets: assert property (p_recal_sets)
      else $error("recal end did not set flag");
   property p_coef_step;
      $rose(recal_done_flag_q) |-> coef_q == $past(coef_q) + 8'h01;
   endproperty
   a_coef_step: assert property (p_coef_step)
      else $error("coefficients not updated");
   property p_status_read;
      rd && frame.addr == dcr_pkg::ADDR_STATUS && !recal_busy_q
      |=> !alarm_q ##1 alarm_n_out;
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("status read did not release alarm");
   property p_soft_reset_trigger;
      soft_reset_trigger |=> clear_code_q == dcr_pkg::CLEAR_CODE_RST && sdo_en_q
               && !recal_done_flag_q;
   endproperty
   a_soft_reset_trigger: assert property (p_soft_reset_trigger)
      else $error("soft reset left state");
   property p_clr_wr;
      wr && !soft_reset_trigger && frame.addr == dcr_pkg::ADDR_CLEAR_CODE
      |=> clear_code_q == $past(frame.data[23:16]);
   endproperty
   a_clr_wr: assert property (p_clr_wr)
      else $error("clear code not written");
   property p_pin_clear;
      !clr_q[2] && !clr_q[1] && !soft_reset_trigger |=> dac_q[19:12] == $past(clear_code_q);
   endproperty
   a_pin_clear: assert property (p_pin_clear)
      else $error("pin clear did not load code");
   property p_soft_clear_trigger_wait;
      soft_clear_trigger_pend_q && !bit32_ev && !sync_rise && !soft_reset_trigger && clr_q[1]
      |=> soft_clear_trigger_pend_q && $stable(dac_q);
   endproperty
   a_soft_clear_trigger_wait: assert property (p_soft_clear_trigger_wait)
      else $error("soft clear applied early");
   property p_sdo_en;
      !sdo_en_q |=> !sdo_en_out;
   endproperty
   a_sdo_en: assert property (p_sdo_en)
      else $error("serial out driven while disabled");

   c_recal: cover property ($rose(recal_done_flag_q));
   c_soft_clear_trigger: cover property ($fell(soft_clear_trigger_pend_q));
   c_read: cover property (rd);
endmodule : dcr_core

// File: common/dcr_pkg.sv
package dcr_pkg;
   // Frame layout of one 32-bit serial register frame.
   localparam int FRAME_BITS = 32;
   localparam int RW_BIT = 31;
   localparam int ADDR_HI = 30;
   localparam int ADDR_LO = 24;
   localparam int DATA_HI = 23;
   // Register addresses.
   localparam logic [6:0] ADDR_CONFIG = 7'h02;
   localparam logic [6:0] ADDR_CLEAR_CODE = 7'h03;
   localparam logic [6:0] ADDR_TRIGGER = 7'h04;
   localparam logic [6:0] ADDR_STATUS = 7'h05;
   // Field positions.
   localparam int CLEAR_CODE_HI = 23;
   localparam int CLEAR_CODE_LO = 16;
   localparam int TRIG_RECAL_BIT = 8;
   localparam int TRIG_SOFT_RESET_TRIGGER_BIT = 6;
   localparam int TRIG_SOFT_CLEAR_TRIGGER_BIT = 5;
   localparam int CFG_ALARM_EN_BIT = 12;
   localparam int CFG_SDO_EN_BIT = 11;
   localparam int STAT_RECAL_DONE_BIT = 12;
   // Reset values.
   localparam logic [7:0] CLEAR_CODE_RST = 8'h00;
   localparam logic CFG_SDO_EN_RST = 1'b1;
   localparam logic CFG_ALARM_EN_RST = 1'b0;
   // Recalibration time.
   localparam int RECAL_TIME_US = 10;
   localparam int CLK_MHZ = 40;
   localparam int RECAL_CYCLES = RECAL_TIME_US * CLK_MHZ;
   localparam int DAC_BITS = 20;

   // One decoded frame passed from the link domain to the core.
   typedef struct packed {
      logic rd;
      logic [6:0] addr;
      logic [23:0] data;
   } dcr_frame_s;
endpackage : dcr_pkg

// File: design/dcr_link.sv
`timescale 1ns/1ps
// Serial shifter on the host's serial clock. Captures 32 bits per frame and
// shifts read data out. Whole frames are handed across by a toggle.
module dcr_link (
   input wire logic sclk_in,
   input wire logic rst_in,
   input wire logic sync_n_in,
   input wire logic sdi_in,
   input wire logic [23:0] rd_data_in,
   output logic sdo_out,
   output dcr_pkg::dcr_frame_s frame_out,
   output logic frame_tgl_out,
   output logic bit32_tgl_out
);
   logic [31:0] shift_q;
   logic [5:0] cnt_q;
   logic [23:0] rd_shift_q;

   // Bit counter. The serial clock rests between frames, so a high frame
   // sync clears the count at once; a cut frame leaves nothing behind.
   always_ff @(posedge sclk_in or posedge rst_in or posedge sync_n_in)
   begin
      if (rst_in)
         cnt_q <= 6'h0;
      else if (sync_n_in)
         cnt_q <= 6'h0;
      else if (cnt_q != 6'h20)
         cnt_q <= cnt_q + 6'h01;
   end

   // Shift in on rising edges; the 32nd bit latches the whole frame.
   always_ff @(posedge sclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         shift_q <= 32'h0;
         frame_out <= '0;
         frame_tgl_out <= 1'b0;
      end
      else if (!sync_n_in)
      begin
         shift_q <= {shift_q[30:0], sdi_in};
         if (cnt_q == 6'h1f)
         begin
            frame_out <= {shift_q[30:0], sdi_in};
            frame_tgl_out <= ~frame_tgl_out;
         end
      end
   end

   // Falling edge: read data out, and the 32nd falling edge event.
   always_ff @(negedge sclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         rd_shift_q <= 24'h0;
         sdo_out <= 1'b0;
         bit32_tgl_out <= 1'b0;
      end
      else if (cnt_q == 6'h08)
      begin
         rd_shift_q <= {rd_data_in[22:0], 1'b0};
         sdo_out <= rd_data_in[23];
      end
      else
      begin
         rd_shift_q <= {rd_shift_q[22:0], 1'b0};
         sdo_out <= rd_shift_q[23];
         if (cnt_q == 6'h20 && !sync_n_in)
            bit32_tgl_out <= ~bit32_tgl_out;
      end
   end
endmodule : dcr_link

// File: dv/dcr_host.sv
`timescale 1ns/1ps
// Host serial controller. The clock runs only inside frames and rests low.
module dcr_host (
   output logic sclk_out,
   output logic sync_n_out,
   output logic sdi_out,
   input wire logic sdo_in,
   input wire logic sdo_en_in
);
   // Idle levels at time zero.
   initial
   begin
      sclk_out = 1'b0;
      sync_n_out = 1'b1;
      sdi_out = 1'b0;
   end

   // Open a frame and shift 32 bits MSB first; sync stays low afterwards.
   // An undriven data-out line gives a changing pattern, never a steady 0.
   task automatic shift(input logic [31:0] w, output logic [31:0] r);
      r = '0;
      sync_n_out = 1'b0;
      for (int i = 31; i >= 0; i--)
      begin
         sdi_out = w[i];
         #80 sclk_out = 1'b1;
         r = {r[30:0], sdo_en_in ? sdo_in : ~r[0]};
         #80 sclk_out = 1'b0;
      end
   endtask : shift

   // Close the frame and keep a gap well above four system cycles.
   task automatic close();
      #80 sync_n_out = 1'b1;
      sdi_out = ~sdi_out;
      #200;
   endtask : close

   // One complete frame.
   task automatic xfer(input logic [31:0] w, output logic [31:0] r);
      shift(w, r);
      close();
   endtask : xfer
endmodule : dcr_host

// File: dv/tb_dac_clear_trigger_regs.sv
`timescale 1ns/1ps
// Frame-level checks of the clear-code and trigger registers.
module tb_dac_clear_trigger_regs;
   localparam int RC = 8;
   logic sys_clk_in, rst_in, sclk, sync_n, sdi, clr_n, sdo, sdo_en, alarm_n;
   logic [19:0] dac_code;
   logic [7:0] cal_coef;
   logic [31:0] r;
   logic [23:0] d;
   int mismatches = 0;
   int n_compared = 0;
   int cycles = 0;

   dcr_core #(.RECAL_CYC(RC)) dut_u (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in), .sclk_in(sclk),
      .sync_n_in(sync_n), .sdi_in(sdi), .clear_input_pin_n_in(clr_n),
      .sdo_out(sdo), .sdo_en_out(sdo_en), .alarm_n_out(alarm_n),
      .dac_code_out(dac_code), .cal_coef_out(cal_coef));
   dcr_host host_u (.sclk_out(sclk), .sync_n_out(sync_n), .sdi_out(sdi),
      .sdo_in(sdo), .sdo_en_in(sdo_en));

   // System clock at 40 MHz.
   initial
   begin
      sys_clk_in = 1'b0;
      forever #12.5 sys_clk_in = ~sys_clk_in;
   end

   // A hang is cut short well above the few thousand cycles the run needs.
   always @(posedge sys_clk_in)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [6:0] a, input logic [23:0] v);
      host_u.xfer({1'b0, a, v}, r);
   endtask : wr

   // Readback comes out during the frame after the addressing one.
   task automatic rd(input logic [6:0] a, output logic [23:0] v);
      host_u.xfer({1'b1, a, 24'h0}, r);
      host_u.xfer({1'b1, a, 24'h0}, r);
      v = r[23:0];
   endtask : rd

   task automatic cfg(input logic recal_done_flag, input logic sdo_on);
      wr(dcr_pkg::ADDR_CONFIG, {11'h0, recal_done_flag, sdo_on, 11'h0});
   endtask : cfg

   task automatic ticks(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask : ticks

   // Soft clear, checked before and after the frame sync rises.
   task automatic soft_clear_trigger(input logic on, input logic [7:0] c,
      input logic [19:0] old);
      cfg(1'b0, on);
      wr(dcr_pkg::ADDR_CLEAR_CODE, {c, 16'h0});
      host_u.shift({1'b0, dcr_pkg::ADDR_TRIGGER, 24'h000020}, r);
      ticks(8);
      chk({4'h0, dac_code}, {4'h0, on ? {c, 12'h0} : old});
      chk({23'h0, sdo_en}, {23'h0, on});
      host_u.close();
      chk({4'h0, dac_code}, {4'h0, c, 12'h0});
   endtask : soft_clear_trigger

   // Recalibration run with the alarm pin enabled or not.
   task automatic recal(input logic recal_done_flag, input logic [7:0] n);
      cfg(recal_done_flag, 1'b1);
      wr(dcr_pkg::ADDR_TRIGGER, 24'h000100);
      ticks(RC + 12);
      chk({23'h0, alarm_n}, {23'h0, ~recal_done_flag});
      chk({16'h0, cal_coef}, {16'h0, n});
   endtask : recal

   // Main sequence.
   initial
   begin
      rst_in = 1'b1;
      clr_n = 1'b1;
      ticks(3);
      rst_in = 1'b0;
      ticks(3);
      chk({23'h0, alarm_n}, 24'h1);
      chk({4'h0, dac_code}, 24'h0);
      chk({16'h0, cal_coef}, 24'h0);
      chk({23'h0, sdo_en}, 24'h0);
      rd(dcr_pkg::ADDR_CLEAR_CODE, d);
      chk(d, 24'h0);
      wr(dcr_pkg::ADDR_CLEAR_CODE, 24'ha50000);
      rd(dcr_pkg::ADDR_CLEAR_CODE, d);
      chk(d, 24'ha50000);
      soft_clear_trigger(1'b1, 8'h5a, 20'h0);
      soft_clear_trigger(1'b0, 8'h3c, 20'h5a000);
      recal(1'b1, 8'h01);
      rd(dcr_pkg::ADDR_STATUS, d);
      chk(d, 24'h001000);
      chk({23'h0, alarm_n}, 24'h1);
      recal(1'b0, 8'h02);
      wr(dcr_pkg::ADDR_CLEAR_CODE, 24'hc30000);
      clr_n = 1'b0;
      ticks(8);
      chk({4'h0, dac_code}, 24'h0c3000);
      clr_n = 1'b1;
      ticks(2);
      wr(7'h7f, 24'hffffff);
      rd(7'h7f, d);
      chk(d, 24'h0);
      wr(dcr_pkg::ADDR_TRIGGER, 24'h000040);
      ticks(8);
      rd(dcr_pkg::ADDR_CLEAR_CODE, d);
      chk(d, 24'h0);
      chk({4'h0, dac_code}, 24'h0);
      end_sim();
   end
endmodule : tb_dac_clear_trigger_regs
